// ==== logic/adma_ctrl.sv ====
// Host controller for an asynchronous fast-page DRAM module.
// Assumes one 200 MHz clock; read data pins arrive asynchronously.
`timescale 1ns/1ps
`include "adma_map.svh"

// Operation
// - wait 200 us after reset, then run eight RAS-only cycles before use.
// - refresh 1024 rows per 16 ms by CAS-before-RAS or RAS-only.
// - each random access cycle lasts at least 150 or 180 ns.
// - open row serves several column cycles, each at least 55 or 60 ns.
// - RAS low in page mode at most 200000 ns, at least 80 or 100 ns.
// - CAS stays high at least 10 ns between page accesses.
// - write strobe low before CAS falls gives early write, outputs off.
// - write strobe high after CAS or RAS ends in a read.
// - CAS low at least 10 ns before RAS falls in CBR refresh.
// - CAS held low at least 30 ns after RAS falls in CBR refresh.
// - write strobe low at least 20 or 25 ns before CAS rises.
module adma_ctrl import adma_pkg::*; #(
  parameter bit FAST_GRADE = 1'b1,
  parameter int INIT_CYC = adma_cyc(`ADMA_INIT_NS),
  parameter int RASP_CYC = `ADMA_TRASP_MAX_NS / `ADMA_CLK_NS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Access request
  input wire logic req_valid,
  input wire adma_req_t req,
  output logic req_ready,
  // Read answer
  output logic rsp_valid,
  output logic [`ADMA_DATA_BITS-1:0] rsp_rdata,
  // Configuration and status
  input wire logic ref_ras_only,
  output logic init_done,
  // Module pins
  output adma_pins_t pins,
  input wire logic [`ADMA_DATA_BITS-1:0] data_lines_in
);
  // ************************************************************
  // Timing in cycles
  // ************************************************************
  localparam int TRC_C = adma_cyc(FAST_GRADE ? `ADMA_F_TRC_NS : `ADMA_S_TRC_NS);
  localparam int TRAS_C = adma_cyc(FAST_GRADE ? `ADMA_F_TRAS_NS : `ADMA_S_TRAS_NS);
  localparam int TRP_C = adma_cyc(FAST_GRADE ? `ADMA_F_TRP_NS : `ADMA_S_TRP_NS);
  localparam int TRCD_C = adma_cyc(FAST_GRADE ? `ADMA_F_TRCD_NS : `ADMA_S_TRCD_NS);
  localparam int TRAH_C = adma_cyc(FAST_GRADE ? `ADMA_F_TRAH_NS : `ADMA_S_TRAH_NS);
  localparam int TCAS_C = adma_cyc(FAST_GRADE ? `ADMA_F_TCAS_NS : `ADMA_S_TCAS_NS);
  localparam int TCWL_C = adma_cyc(FAST_GRADE ? `ADMA_F_TCWL_NS : `ADMA_S_TCWL_NS);
  localparam int TAA_C = adma_cyc(FAST_GRADE ? `ADMA_F_TAA_NS : `ADMA_S_TAA_NS);
  localparam int TPC_C = adma_cyc(FAST_GRADE ? `ADMA_F_TPC_NS : `ADMA_S_TPC_NS);
  localparam int TCSH_C = adma_cyc(FAST_GRADE ? `ADMA_F_TCSH_NS : `ADMA_S_TCSH_NS);
  localparam int TCP_C = adma_cyc(`ADMA_TCP_NS);
  localparam int TCSR_C = adma_cyc(`ADMA_TCSR_NS);
  localparam int TCHR_C = adma_cyc(`ADMA_TCHR_NS);
  localparam int REF_INT_C = `ADMA_TREF_MS * 1000000 / `ADMA_REF_ROWS / `ADMA_CLK_NS;
  // Write CAS pulse covers both CAS width and write lead
  localparam int TCASW_C = (TCAS_C > TCWL_C) ? TCAS_C : TCWL_C;
  // Read CAS pulse also pays for the pin synchroniser
  localparam int TCASR_C = ((TAA_C > TCAS_C) ? TAA_C : TCAS_C) + `ADMA_SYNC_STAGES + 1;
  localparam int COLW_C = (TRCD_C > TRAH_C + 1) ? TRCD_C - TRAH_C - 1 : 0;
  localparam int CBR_C = (TRAS_C > TCHR_C) ? TRAS_C : TCHR_C;
  localparam int PAGE_LIM = RASP_CYC - `ADMA_PAGE_MARGIN;

  if (INIT_CYC < 1 || INIT_CYC > 65535 || PAGE_LIM < TRC_C || RASP_CYC > 65535)
  begin : g_chk
    $error("adma_ctrl: timing parameter out of range");
  end

  localparam adma_regs_t RST_VAL = '{
    state: S_INIT_WAIT, cnt: 16'(INIT_CYC - 1), rc: 16'hFFFF, pc: 16'hFFFF,
    init_left: 4'(`ADMA_INIT_RAS), ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
    addr: '0, open_row: '0, ref_row: '0, dq_out: '0, dq_oe: 1'b0, cur: '0,
    rdata: '0, sync1: '0, sync2: '0, rsp_valid: 1'b0, ref_ack: 1'b0};

  adma_regs_t st;
  adma_regs_t nx;
  logic ref_due;
  logic row_hit;
  logic page_ok;

  // ************************************************************
  // Refresh pacing
  // ************************************************************
  adma_refresh_timer #(.INTERVAL(REF_INT_C)) u_ref (
    .mclk(mclk),
    .rst(rst),
    .ack(st.ref_ack),
    .due(ref_due)
  );

  // ************************************************************
  // Access sequencer
  // ************************************************************
  // Page reuse only while the row is young enough to finish an access
  assign row_hit = (req.row == st.open_row);
  assign page_ok = !ref_due && (st.rc < 16'(PAGE_LIM));
  assign req_ready = (st.state == S_IDLE && !ref_due)
                   || (st.state == S_PAGE && page_ok && row_hit);

  always_comb begin
    nx = st;
    nx.rsp_valid = 1'b0;
    nx.ref_ack = 1'b0;
    nx.sync1 = data_lines_in;
    nx.sync2 = st.sync1;
    case (st.state)
      S_INIT_WAIT: begin
        if (st.cnt == 16'h0000) begin
          nx.state = S_RO_LOW;
          nx.ras_n = 1'b0;
          nx.addr = st.ref_row;
        end else begin
          nx.cnt = st.cnt - 16'h0001;
        end
      end
      S_RO_LOW: begin
        if (st.rc >= 16'(TRAS_C - 1)) begin
          nx.ras_n = 1'b1;
          nx.ref_row = st.ref_row + 11'h001;
          nx.state = S_RAS_PRE;
          nx.cnt = 16'(TRP_C - 1);
          if (st.init_left != 4'h0) begin
            nx.init_left = st.init_left - 4'h1;
          end
        end
      end
      S_RAS_PRE: begin
        if (st.cnt != 16'h0000) begin
          nx.cnt = st.cnt - 16'h0001;
        end else if (st.rc >= 16'(TRC_C - 1)) begin
          if (st.init_left != 4'h0) begin
            nx.state = S_RO_LOW;
            nx.ras_n = 1'b0;
            nx.addr = st.ref_row;
          end else begin
            nx.state = S_IDLE;
          end
        end
      end
      S_IDLE: begin
        if (ref_due) begin
          nx.ref_ack = 1'b1;
          if (ref_ras_only) begin
            nx.state = S_RO_LOW;
            nx.ras_n = 1'b0;
            nx.addr = st.ref_row;
          end else begin
            nx.state = S_CBR_CAS;
            nx.cas_n = 1'b0;
            nx.cnt = 16'(TCSR_C - 1);
          end
        end else if (req_valid) begin
          nx.state = S_ROW;
          nx.ras_n = 1'b0;
          nx.addr = req.row;
          nx.open_row = req.row;
          nx.cur = req;
          nx.cnt = 16'(TRAH_C - 1);
        end
      end
      S_ROW: begin
        if (st.cnt == 16'h0000) begin
          nx.state = S_COL;
          nx.addr = st.cur.col;
          nx.we_n = !st.cur.write;
          nx.dq_out = st.cur.wdata;
          nx.dq_oe = st.cur.write;
          nx.cnt = 16'(COLW_C);
        end else begin
          nx.cnt = st.cnt - 16'h0001;
        end
      end
      S_COL: begin
        if (st.cnt != 16'h0000) begin
          nx.cnt = st.cnt - 16'h0001;
        end else if (st.pc >= 16'(TPC_C - 1)) begin
          nx.state = S_CAS;
          nx.cas_n = 1'b0;
          nx.cnt = st.cur.write ? 16'(TCASW_C - 1) : 16'(TCASR_C - 1);
        end
      end
      S_CAS: begin
        if (st.cnt != 16'h0000) begin
          nx.cnt = st.cnt - 16'h0001;
        end else if (st.rc >= 16'(TCSH_C - 1)) begin
          nx.cas_n = 1'b1;
          nx.we_n = 1'b1;
          nx.dq_oe = 1'b0;
          nx.state = S_CAS_PRE;
          nx.cnt = 16'(TCP_C - 1);
          if (!st.cur.write) begin
            nx.rdata = st.sync2;
            nx.rsp_valid = 1'b1;
          end
        end
      end
      S_CAS_PRE: begin
        if (st.cnt == 16'h0000) begin
          nx.state = S_PAGE;
        end else begin
          nx.cnt = st.cnt - 16'h0001;
        end
      end
      S_PAGE: begin
        if (!page_ok || (req_valid && !row_hit)) begin
          if (st.rc >= 16'(TRAS_C - 1)) begin
            nx.ras_n = 1'b1;
            nx.state = S_RAS_PRE;
            nx.cnt = 16'(TRP_C - 1);
          end
        end else if (req_valid) begin
          nx.state = S_COL;
          nx.cur = req;
          nx.addr = req.col;
          nx.we_n = !req.write;
          nx.dq_out = req.wdata;
          nx.dq_oe = req.write;
          nx.cnt = 16'h0000;
        end
      end
      S_CBR_CAS: begin
        if (st.cnt == 16'h0000) begin
          nx.state = S_CBR_RAS;
          nx.ras_n = 1'b0;
        end else begin
          nx.cnt = st.cnt - 16'h0001;
        end
      end
      S_CBR_RAS: begin
        if (st.rc >= 16'(CBR_C - 1)) begin
          nx.ras_n = 1'b1;
          nx.cas_n = 1'b1;
          nx.state = S_RAS_PRE;
          nx.cnt = 16'(TRP_C - 1);
        end
      end
      default: begin
        nx = RST_VAL;
      end
    endcase
    // Cycle ages since the last strobe fall, saturating
    if (st.ras_n && !nx.ras_n) begin
      nx.rc = 16'h0000;
    end else if (st.rc != 16'hFFFF) begin
      nx.rc = st.rc + 16'h0001;
    end
    if (st.cas_n && !nx.cas_n) begin
      nx.pc = 16'h0000;
    end else if (st.pc != 16'hFFFF) begin
      nx.pc = st.pc + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= RST_VAL;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from the state register
  assign pins = '{ras_n: st.ras_n, cas_n: st.cas_n, we_n: st.we_n,
                  mux_address_lines: st.addr, data_lines_out: st.dq_out,
                  data_lines_oe: st.dq_oe};
  assign rsp_valid = st.rsp_valid;
  assign rsp_rdata = st.rdata;
  assign init_done = (st.init_left == 4'h0);

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_init_quiet: assert property (st.state == S_INIT_WAIT |-> pins.ras_n && pins.cas_n)
    else $error("strobe moved during power-up wait");
  a_init_ready: assert property (req_ready |-> st.init_left == 4'h0)
    else $error("access taken before init RAS cycles");
  a_trc_min: assert property ($fell(pins.ras_n) |-> $past(st.rc) >= 16'(TRC_C - 1))
    else $error("RAS cycle shorter than cycle time");
  a_ref_served: assert property ($rose(ref_due) && init_done |-> ##[0:120] st.ref_ack)
    else $error("refresh not issued in time");
  a_page_cycle: assert property ($fell(pins.cas_n) |-> $past(st.pc) >= 16'(TPC_C - 1))
    else $error("CAS cycle shorter than page cycle");
  a_ras_max: assert property (!pins.ras_n |-> st.rc < 16'(RASP_CYC))
    else $error("RAS held low too long");
  a_ras_min: assert property ($rose(pins.ras_n) |-> $past(st.rc) >= 16'(TRAS_C - 1))
    else $error("RAS pulse too short");
  a_cas_pre: assert property ($rose(pins.cas_n) |-> pins.cas_n[*2])
    else $error("CAS precharge too short");
  a_cbr_setup: assert property ($fell(pins.ras_n) && !pins.cas_n |-> $past(pins.cas_n, 2) == 1'b0)
    else $error("CAS set-up before RAS too short");
  a_cbr_hold: assert property ($fell(pins.ras_n) && !pins.cas_n |-> !pins.cas_n[*6])
    else $error("CAS hold after RAS too short");
  a_we_lead: assert property ($rose(pins.cas_n) && !$past(pins.we_n) |-> $past(st.pc) >= 16'(TCWL_C - 1))
    else $error("write strobe lead to CAS end too short");
  a_early_we: assert property ($fell(pins.cas_n) && !pins.we_n |-> $past(pins.we_n) == 1'b0)
    else $error("write strobe not ahead of CAS");
  a_read_we: assert property ($rose(pins.cas_n) && $past(pins.we_n) |-> pins.we_n[*2])
    else $error("write strobe fell after a read");
  a_row_addr: assert property ($fell(pins.ras_n) && pins.cas_n && st.state == S_ROW |-> pins.mux_address_lines == st.open_row)
    else $error("row address wrong at RAS fall");

  c_read: cover property (rsp_valid);
  c_write: cover property ($rose(pins.cas_n) && !$past(pins.we_n));
  c_page_hit: cover property (st.state == S_PAGE && req_valid && req_ready);
  c_cbr: cover property ($fell(pins.ras_n) && !pins.cas_n);
endmodule // adma_ctrl

// ==== inc/adma_map.svh ====
// Timing figures and fixed sizes for the asynchronous DRAM module controller.
// Assumes a single 200 MHz system clock; figures are in their printed units.
`ifndef ADMA_MAP_SVH
`define ADMA_MAP_SVH

// Clock and sizes
`define ADMA_CLK_NS 5
`define ADMA_ROW_BITS 11
`define ADMA_DATA_BITS 8
`define ADMA_SYNC_STAGES 2

// Power-up and refresh
`define ADMA_INIT_NS 200000
`define ADMA_INIT_RAS 8
`define ADMA_REF_ROWS 1024
`define ADMA_TREF_MS 16
`define ADMA_TRASP_MAX_NS 200000

// Fast grade figures in ns
`define ADMA_F_TRC_NS 150
`define ADMA_F_TRAS_NS 80
`define ADMA_F_TRP_NS 60
`define ADMA_F_TRCD_NS 25
`define ADMA_F_TRAH_NS 10
`define ADMA_F_TCAS_NS 20
`define ADMA_F_TCWL_NS 20
`define ADMA_F_TAA_NS 40
`define ADMA_F_TPC_NS 55
`define ADMA_F_TCSH_NS 80

// Slow grade figures in ns
`define ADMA_S_TRC_NS 180
`define ADMA_S_TRAS_NS 100
`define ADMA_S_TRP_NS 70
`define ADMA_S_TRCD_NS 25
`define ADMA_S_TRAH_NS 15
`define ADMA_S_TCAS_NS 25
`define ADMA_S_TCWL_NS 25
`define ADMA_S_TAA_NS 50
`define ADMA_S_TPC_NS 60
`define ADMA_S_TCSH_NS 100

// Figures shared by both grades in ns
`define ADMA_TCP_NS 10
`define ADMA_TCSR_NS 10
`define ADMA_TCHR_NS 30

// Page is closed this many cycles before the longest row-open time
`define ADMA_PAGE_MARGIN 64

`endif

// ==== inc/adma_pkg.sv ====
// Types shared by the DRAM module controller files.
// Assumes adma_map.svh is on the include path.
package adma_pkg;
  `include "adma_map.svh"

  typedef enum logic [3:0] {
    S_INIT_WAIT, S_RO_LOW, S_RAS_PRE, S_IDLE, S_ROW, S_COL,
    S_CAS, S_CAS_PRE, S_PAGE, S_CBR_CAS, S_CBR_RAS
  } adma_state_t;

  typedef struct packed {
    logic write;
    logic [`ADMA_ROW_BITS-1:0] row;
    logic [`ADMA_ROW_BITS-1:0] col;
    logic [`ADMA_DATA_BITS-1:0] wdata;
  } adma_req_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [`ADMA_ROW_BITS-1:0] mux_address_lines;
    logic [`ADMA_DATA_BITS-1:0] data_lines_out;
    logic data_lines_oe;
  } adma_pins_t;

  typedef struct packed {
    adma_state_t state;
    logic [15:0] cnt;
    logic [15:0] rc;
    logic [15:0] pc;
    logic [3:0] init_left;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [`ADMA_ROW_BITS-1:0] addr;
    logic [`ADMA_ROW_BITS-1:0] open_row;
    logic [`ADMA_ROW_BITS-1:0] ref_row;
    logic [`ADMA_DATA_BITS-1:0] dq_out;
    logic dq_oe;
    adma_req_t cur;
    logic [`ADMA_DATA_BITS-1:0] rdata;
    logic [`ADMA_DATA_BITS-1:0] sync1;
    logic [`ADMA_DATA_BITS-1:0] sync2;
    logic rsp_valid;
    logic ref_ack;
  } adma_regs_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic due;
  } adma_tmr_t;

  // Least time in ns to whole clock cycles, rounded up, at least one
  function automatic int adma_cyc(input int ns);
    int c;
    c = (ns + `ADMA_CLK_NS - 1) / `ADMA_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
endpackage

// ==== logic/adma_refresh_timer.sv ====
// Refresh interval timer: raises a sticky request once per row interval.
// Assumes the acknowledge is a one-cycle pulse from the controller.
`timescale 1ns/1ps
module adma_refresh_timer import adma_pkg::*; #(
  parameter int INTERVAL = 3125
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Request and acknowledge
  input wire logic ack,
  output logic due
);
  adma_tmr_t st;
  adma_tmr_t nx;

  if (INTERVAL < 2 || INTERVAL > 4095) begin : g_chk
    $error("adma_refresh_timer: INTERVAL out of range");
  end

  // Count down; a new tick beats an acknowledge in the same cycle
  always_comb begin
    nx = st;
    if (st.cnt == 12'h000) begin
      nx.cnt = 12'(INTERVAL - 1);
      nx.due = 1'b1;
    end else begin
      nx.cnt = st.cnt - 12'h001;
      if (ack) begin
        nx.due = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '{cnt: 12'(INTERVAL - 1), due: 1'b0};
    end else begin
      st <= nx;
    end
  end

  assign due = st.due;
endmodule // adma_refresh_timer

// ==== bench/adma_dram_model.sv ====
// Behavioural model of the DRAM module seen from its strobe and data pins.
// Assumes the controller drives registered pins; timing is judged in real ns.
`timescale 1ns/1ps
`include "adma_map.svh"
module adma_dram_model import adma_pkg::*; #(
  parameter bit FAST = 1'b1
) (
  // Pins from the controller
  input wire adma_pins_t pins,
  // Read data back to the controller
  output logic [`ADMA_DATA_BITS-1:0] data_lines_in,
  // Activity and fault counts
  output int n_ras,
  output int n_cbr,
  output int n_ras_only,
  output int n_page,
  output int n_viol
);
  localparam realtime TRC = FAST ? 150 : 180;
  localparam realtime TRAS = FAST ? 80 : 100;
  localparam realtime TRP = FAST ? 60 : 70;
  localparam realtime TPC = FAST ? 55 : 60;
  localparam realtime TCWL = FAST ? 20 : 25;
  localparam realtime TCAC = FAST ? 20 : 25;
  localparam realtime TOFF = FAST ? 15 : 20;
  realtime t_rf = -1.0e6;
  realtime t_rr = -1.0e6;
  realtime t_cf = -1.0e6;
  realtime t_cr = -1.0e6;
  realtime t_wf = -1.0e6;
  logic [10:0] row = 11'h000;
  logic [10:0] col = 11'h000;
  logic [7:0] rd_val = 8'h00;
  logic [7:0] mem [int];
  bit ras_low, cas_low, cbr, cas_seen, wr, dq_on;
  initial {n_ras, n_cbr, n_ras_only, n_page, n_viol} = '0;
  // **********************************
  // Row strobe
  // **********************************
  always @(negedge pins.ras_n) if (pins.ras_n === 1'b0) begin
    if ($realtime - t_rf < TRC || $realtime - t_rr < TRP) n_viol++;
    cbr = (pins.cas_n === 1'b0);
    if (cbr && $realtime - t_cf < `ADMA_TCSR_NS) n_viol++;
    if (cbr) n_cbr++;
    row = pins.mux_address_lines;
    ras_low = 1'b1;
    cas_seen = 1'b0;
    t_rf = $realtime;
  end
  // Row-only cycles count as refresh as well as power-up cycles
  always @(posedge pins.ras_n) if (ras_low) begin
    if ($realtime - t_rf < TRAS || $realtime - t_rf > `ADMA_TRASP_MAX_NS) n_viol++;
    if (!cbr && !cas_seen) n_ras_only++;
    n_ras++;
    ras_low = 1'b0;
    t_rr = $realtime;
  end
  // **********************************
  // Column strobe and data
  // **********************************
  always @(negedge pins.cas_n) if (pins.cas_n === 1'b0) begin
    if ($realtime - t_cr < `ADMA_TCP_NS) n_viol++;
    if (ras_low && !cbr) begin
      if (cas_seen) n_page++;
      if (cas_seen && $realtime - t_cf < TPC) n_viol++;
      col = pins.mux_address_lines;
      wr = (pins.we_n === 1'b0);
      if (wr && pins.data_lines_oe !== 1'b1) n_viol++;
      if (wr) mem[{row, col}] = pins.data_lines_out;
      else begin
        rd_val = mem.exists({row, col}) ? mem[{row, col}] : 8'h00;
        dq_on <= #(TCAC) 1'b1;
      end
      cas_seen = 1'b1;
    end
    cas_low = 1'b1;
    t_cf = $realtime;
  end
  always @(posedge pins.cas_n) if (cas_low) begin
    if (cbr && $realtime - t_rf < `ADMA_TCHR_NS) n_viol++;
    if (wr && $realtime - t_wf < TCWL) n_viol++;
    dq_on <= #(TOFF) 1'b0;
    wr = 1'b0;
    cas_low = 1'b0;
    t_cr = $realtime;
  end
  always @(negedge pins.we_n) t_wf = $realtime;
  // Both sides driving the data lines at once is a fault
  always @(posedge dq_on) if (pins.data_lines_oe) n_viol++;
  // No pull-ups: a released bus shows the inverse of the last word
  assign data_lines_in = dq_on ? rd_val : ~rd_val;
endmodule // adma_dram_model

// ==== bench/testbench.sv ====
// Self-checking bench for the DRAM module controller.
// Assumes the module model answers on the pins; counts are short for speed.
`timescale 1ns/1ps
module testbench import adma_pkg::*;;
  localparam int INIT_CYC = 50;
  localparam int RASP_CYC = 200;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  adma_req_t req = '0;
  logic ref_ras_only = 1'b0;
  logic req_ready, rsp_valid, init_done;
  logic [7:0] rsp_rdata, data_lines_in;
  adma_pins_t pins;
  int n_ras, n_cbr, n_ras_only, n_page, n_viol;
  int fails = 0;
  int n_compared = 0;
  adma_ctrl #(.FAST_GRADE(1'b1), .INIT_CYC(INIT_CYC), .RASP_CYC(RASP_CYC)) adma_ctrl_i (
    .mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ref_ras_only(ref_ras_only),
    .init_done(init_done), .pins(pins), .data_lines_in(data_lines_in));
  adma_dram_model #(.FAST(1'b1)) adma_dram_model_i (
    .pins(pins), .data_lines_in(data_lines_in), .n_ras(n_ras), .n_cbr(n_cbr),
    .n_ras_only(n_ras_only), .n_page(n_page), .n_viol(n_viol));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // **********************************
  // Shared tasks
  // **********************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One request held until taken; reads wait for the answer under a bound
  task automatic access(input logic wr, input logic [10:0] row, input logic [10:0] col,
                        input logic [7:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{write: wr, row: row, col: col, wdata: d};
    do begin
      @(negedge mclk);
      k++;
    end while (req_ready !== 1'b1 && k < 4000);
    if (req_ready !== 1'b1) check("request taken", 1, 0);
    @(posedge mclk);
    req_valid <= 1'b0;
    if (!wr) begin
      k = 0;
      do begin
        @(negedge mclk);
        k++;
      end while (rsp_valid !== 1'b1 && k < 100);
      if (rsp_valid !== 1'b1) check("read answer", 1, 0);
      check("read data", {24'h0, d}, {24'h0, rsp_rdata});
    end
  endtask
  // **********************************
  // Scenarios
  // **********************************
  task automatic t_init();
    int k;
    repeat (INIT_CYC - 1) @(negedge mclk);
    check("cycles before wait", 0, n_ras);
    @(negedge mclk);
    check("row strobe held in wait", 1, {31'h0, pins.ras_n});
    @(negedge mclk);
    check("first power-up row strobe", 0, {31'h0, pins.ras_n});
    k = 0;
    while (init_done !== 1'b1 && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    check("init done", 1, {31'h0, init_done});
    check("power-up cycles", 8, n_ras_only);
  endtask
  // Opposite corners of row and column catch swapped or shifted addresses
  task automatic t_corners();
    access(1'b1, 11'h7FF, 11'h000, 8'hA5);
    access(1'b1, 11'h000, 11'h7FF, 8'h5A);
    access(1'b1, 11'h7FF, 11'h7FF, 8'hC3);
    access(1'b0, 11'h7FF, 11'h000, 8'hA5);
    access(1'b0, 11'h000, 11'h7FF, 8'h5A);
    access(1'b0, 11'h7FF, 11'h7FF, 8'hC3);
  endtask
  task automatic t_page();
    int p0;
    p0 = n_page;
    for (int i = 0; i < 4; i++) access(1'b1, 11'h123, 11'(i), 8'(8'h30 + i));
    for (int i = 0; i < 4; i++) access(1'b0, 11'h123, 11'(i), 8'(8'h30 + i));
    check("page hits", 1, {31'h0, n_page - p0 >= 4});
  endtask
  // An idle open page must close before the row-open limit
  task automatic t_age();
    access(1'b0, 11'h123, 11'h001, 8'h31);
    repeat (RASP_CYC) @(negedge mclk);
    check("page closed by age", 1, {31'h0, pins.ras_n});
  endtask
  task automatic t_refresh(input logic ras_only);
    int c0, r0;
    @(posedge mclk);
    ref_ras_only <= ras_only;
    repeat (40) @(negedge mclk);
    c0 = n_cbr;
    r0 = n_ras_only;
    repeat (3300) @(negedge mclk);
    check("strobe-first refresh", {31'h0, !ras_only}, {31'h0, n_cbr > c0});
    check("row-only refresh", {31'h0, ras_only}, {31'h0, n_ras_only > r0});
  endtask
  // **********************************
  // Main sequence and watchdog
  // **********************************
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    check("strobes idle in reset", 32'h7, {29'h0, pins.ras_n, pins.cas_n, pins.we_n});
    check("quiet in reset", 0, {29'h0, pins.data_lines_oe, init_done, req_ready});
    @(posedge mclk);
    rst <= 1'b0;
    t_init();
    t_corners();
    t_page();
    t_age();
    t_refresh(1'b0);
    t_refresh(1'b1);
    access(1'b0, 11'h000, 11'h7FF, 8'h5A);
    check("module timing faults", 0, n_viol);
    final_report();
  end
  // Tests need about 7600 cycles; over twice that means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    final_report();
  end
endmodule // testbench
